// [rtl/ppim_map.svh]
// Register offsets, field positions, reset values and timing counts of the panel image mapper.
// Assumes a 32-bit classic Wishbone slave with byte addresses and a 250 MHz core clock.
`ifndef PPIM_MAP_SVH
`define PPIM_MAP_SVH

`define PPIM_ADDR_KEYS      8'h00
`define PPIM_ADDR_STDIN     8'h04
`define PPIM_ADDR_LED_LO    8'h08
`define PPIM_ADDR_LED_HI    8'h0c
`define PPIM_ADDR_STDOUT    8'h10
`define PPIM_ADDR_CFG       8'h14
`define PPIM_ADDR_FSIN0     8'h18
`define PPIM_ADDR_FSIN1     8'h1c
`define PPIM_ADDR_FSOUT     8'h20
`define PPIM_ADDR_IRQSTAT   8'h24
`define PPIM_ADDR_IRQMASK   8'h28
`define PPIM_ADDR_RESERVE   8'h2c

`define PPIM_CFG_COMBO_LSB  0
`define PPIM_CFG_FSBASE_LSB 8
`define PPIM_RES_OUT_LSB    16

`define PPIM_IRQ_KEY        0
`define PPIM_IRQ_STDIN      1
`define PPIM_IRQ_ESTOP1     2
`define PPIM_IRQ_ESTOP2     3
`define PPIM_IRQ_DISC       4
`define PPIM_IRQ_BITS       5

`define PPIM_CFG_RST        32'h0000_0000
`define PPIM_IMG_RST        32'h0000_0000
`define PPIM_MASK_RST       5'h00
`define PPIM_RESERVE_RST    24'h00_0000

`define PPIM_CLK_PERIOD_NS  4
`define PPIM_FAST_PERIOD_NS 500000000
`define PPIM_SLOW_PERIOD_NS 2000000000
`define PPIM_DISC_TIME_NS   500000000
`define PPIM_FAST_HALF_CYC  (`PPIM_FAST_PERIOD_NS / 2 / `PPIM_CLK_PERIOD_NS)
`define PPIM_SLOW_HALF_CYC  (`PPIM_SLOW_PERIOD_NS / 2 / `PPIM_CLK_PERIOD_NS)
`define PPIM_DISC_CYC       ((`PPIM_DISC_TIME_NS + `PPIM_CLK_PERIOD_NS - 1) / `PPIM_CLK_PERIOD_NS)

`endif

// [rtl/ppim_pkg.sv]
// Types shared by the panel image mapper files.
// Assumes nothing beyond a SystemVerilog compiler.
package ppim_pkg;

    typedef enum logic [1:0] {
        PPIM_COMBO_FLASH_GREEN  = 2'b00,
        PPIM_COMBO_YELLOW       = 2'b01,
        PPIM_COMBO_FLASH_YELLOW = 2'b10,
        PPIM_COMBO_FLASH_RED    = 2'b11
    } ppim_combo_e;

endpackage

// [rtl/ppim_sync.sv]
// Two-flop synchroniser for a bus of pin levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module ppim_sync #(
    parameter int W = 1
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// [rtl/ppim_flash.sv]
// Square-wave flash generator from a divider enable pulse.
// Assumes HALF is the number of core cycles per half period, at least one.
`timescale 1ns/1ps
`default_nettype none
module ppim_flash #(
    parameter int unsigned HALF = 1
)(
    input  wire logic clk,
    input  wire logic rst,
    output var  logic wave
);
    logic [31:0] divCnt;
    wire         tick = (divCnt == 32'(HALF - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt <= 32'h0000_0000;
            wave   <= 1'b0;
        end else begin
            divCnt <= tick ? 32'h0000_0000 : divCnt + 32'h0000_0001;
            if (tick) begin
                wave <= ~wave;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/ppim_top.sv]
// Panel process image mapper: keys, inputs, key LEDs, outputs and fail-safe area over Wishbone.
// Assumes a classic Wishbone master on core_clk and raw panel pins from outside the domain.
`timescale 1ns/1ps
`default_nettype none
`include "ppim_map.svh"
module ppim_top #(
    parameter int unsigned FAST_HALF = `PPIM_FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF = `PPIM_SLOW_HALF_CYC,
    parameter int unsigned DISC_CYC  = `PPIM_DISC_CYC
)(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    output var  logic        irq,
    input  wire logic [31:0] keyPins,
    input  wire logic [31:0] stdInPins,
    input  wire logic [1:0]  safeChanInput1,
    input  wire logic [1:0]  safeChanInput2,
    output var  logic [31:0] ledRed,
    output var  logic [31:0] ledGreen,
    output var  logic [7:0]  stdOutPins
);

    // Pin synchronisation
    logic [31:0] keySync;
    logic [31:0] stdInSync;
    logic [1:0]  chanASync;
    logic [1:0]  chanBSync;

    ppim_sync #(
        .W (68)
    ) pinSync (
        .clk (core_clk),
        .rst (sys_rst),
        .d   ({safeChanInput2, safeChanInput1, stdInPins, keyPins}),
        .q   ({chanBSync, chanASync, stdInSync, keySync})
    );

    // Flash sources
    logic fastWave;
    logic slowWave;

    ppim_flash #(
        .HALF (FAST_HALF)
    ) fastFlash (
        .clk  (core_clk),
        .rst  (sys_rst),
        .wave (fastWave)
    );

    ppim_flash #(
        .HALF (SLOW_HALF)
    ) slowFlash (
        .clk  (core_clk),
        .rst  (sys_rst),
        .wave (slowWave)
    );

    // Registers
    logic [31:0]                ledImgLo;
    logic [31:0]                ledImgHi;
    logic [15:0]                outImg;
    logic [31:0]                cfgReg;
    logic [31:0]                fsOutImg;
    logic [23:0]                reserveReg;
    logic [`PPIM_IRQ_BITS-1:0]  irqStatus;
    logic [`PPIM_IRQ_BITS-1:0]  irqMask;
    logic [31:0]                keyPrev;
    logic [31:0]                stdInPrev;

    // Bus decode
    // Ack gates the request, so a strobe still held in the ack cycle is not taken twice
    wire        busReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        busWr     = busReq & wb_we_i;
    wire        busRd     = busReq & ~wb_we_i;
    wire [7:0]  wordAdr   = {wb_adr_i[7:2], 2'b00};
    wire        selLedLo  = wordAdr == `PPIM_ADDR_LED_LO;
    wire        selLedHi  = wordAdr == `PPIM_ADDR_LED_HI;
    wire        selStdOut = wordAdr == `PPIM_ADDR_STDOUT;
    wire        selCfg    = wordAdr == `PPIM_ADDR_CFG;
    wire        selFsOut  = wordAdr == `PPIM_ADDR_FSOUT;
    wire        selStat   = wordAdr == `PPIM_ADDR_IRQSTAT;
    wire        selMask   = wordAdr == `PPIM_ADDR_IRQMASK;
    wire        selRes    = wordAdr == `PPIM_ADDR_RESERVE;
    wire        selKeys   = wordAdr == `PPIM_ADDR_KEYS;
    wire        selStdIn  = wordAdr == `PPIM_ADDR_STDIN;
    wire        selFsIn0  = wordAdr == `PPIM_ADDR_FSIN0;
    wire        selFsIn1  = wordAdr == `PPIM_ADDR_FSIN1;
    wire [31:0] byteMask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Write strobes
    wire        wrLedLo   = busWr & selLedLo;
    wire        wrLedHi   = busWr & selLedHi;
    wire        wrStdOut  = busWr & selStdOut;
    wire        wrCfg     = busWr & selCfg;
    wire        wrFsOut   = busWr & selFsOut;
    wire        wrRes     = busWr & selRes;
    wire        wrMask    = busWr & selMask;

    function automatic logic [31:0] mergeWr(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [31:0] msk);
        mergeWr = (old & ~msk) | (wr & msk);
    endfunction

    // Fail-safe channel evaluation
    logic [1:0] estopFlag;
    logic [1:0] discFault;
    logic [1:0] discHit;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : gEstop
            logic [31:0] discCnt;
            wire         agree   = chanASync[gi] == chanBSync[gi];
            wire         atLimit = discCnt == 32'(DISC_CYC);
            assign discHit[gi]   = ~agree & (discCnt == 32'(DISC_CYC - 1));
            assign discFault[gi] = atLimit;

            // Saturates, so a held disagreement never wraps and re-arms
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    discCnt <= 32'h0000_0000;
                end else if (agree) begin
                    discCnt <= 32'h0000_0000;
                end else if (!atLimit) begin
                    discCnt <= discCnt + 32'h0000_0001;
                end
            end

            // Pressed while both channels agree high, zero once disagreement outlasts the limit
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    estopFlag[gi] <= 1'b0;
                end else if (agree) begin
                    estopFlag[gi] <= chanASync[gi];
                end else if (discHit[gi] || discFault[gi]) begin
                    estopFlag[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Image words
    wire [15:0] resIn      = reserveReg[15:0];
    wire [7:0]  resOut     = reserveReg[23:16];
    wire [31:0] keyWord    = {keySync[31:16], keySync[15:0]};
    wire [31:0] stdInWord  = {stdInSync[31:16], stdInSync[15:0] & ~resIn};
    wire [31:0] fsInWord0  = {16'h0000, 4'h0, chanBSync, chanASync, 6'h00, estopFlag};
    wire [31:0] fsInWord1  = 32'h0000_0000;
    wire [1:0]  comboMode  = cfgReg[`PPIM_CFG_COMBO_LSB +: 2];

    // LED decode
    logic [31:0] next_ledRed;
    logic [31:0] next_ledGreen;
    wire  [31:0] redBits   = {ledImgHi[15:0], ledImgLo[15:0]};
    wire  [31:0] greenBits = {ledImgHi[31:16], ledImgLo[31:16]};
    wire         comboRed  = (comboMode == ppim_pkg::PPIM_COMBO_YELLOW) |
                             (((comboMode == ppim_pkg::PPIM_COMBO_FLASH_YELLOW) |
                               (comboMode == ppim_pkg::PPIM_COMBO_FLASH_RED)) & fastWave);
    wire         comboGrn  = (comboMode == ppim_pkg::PPIM_COMBO_YELLOW) |
                             (((comboMode == ppim_pkg::PPIM_COMBO_FLASH_YELLOW) |
                               (comboMode == ppim_pkg::PPIM_COMBO_FLASH_GREEN)) & fastWave);

    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : gLed
            wire both = redBits[gi] & greenBits[gi];
            assign next_ledRed[gi]   = both ? comboRed : redBits[gi];
            assign next_ledGreen[gi] = both ? comboGrn : greenBits[gi];
        end
    endgenerate

    // Output decode
    logic [7:0] next_stdOut;
    wire  [7:0] outFirst  = outImg[7:0];
    wire  [7:0] outSecond = outImg[15:8];

    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : gOut
            wire [1:0] pairCode = {outSecond[gi], outFirst[gi]};
            wire       driven   = (pairCode == 2'b01) |
                                  ((pairCode == 2'b10) & fastWave) |
                                  ((pairCode == 2'b11) & slowWave);
            assign next_stdOut[gi] = driven & ~resOut[gi];
        end
    endgenerate

    // Events: a key or input change, a fresh press, a discrepancy timeout
    logic [1:0] estopPrev;
    wire        keyChange = |(keyWord ^ keyPrev);
    wire        inChange  = |(stdInWord ^ stdInPrev);
    wire [1:0]  estopRise = estopFlag & ~estopPrev;
    wire        discEvent = |discHit;
    wire [`PPIM_IRQ_BITS-1:0] events = {
        discEvent,
        estopRise,
        inChange,
        keyChange
    };
    wire        statClear = busRd & selStat;
    wire [`PPIM_IRQ_BITS-1:0] next_irqStatus = (statClear ? `PPIM_MASK_RST : irqStatus) | events;
    wire        irqPending = |(irqStatus & irqMask);

    // Read mux
    wire [31:0] rdData =
        selKeys                         ? keyWord :
        selStdIn                        ? stdInWord :
        selLedLo                        ? ledImgLo :
        selLedHi                        ? ledImgHi :
        selStdOut                       ? {16'h0000, outImg} :
        selCfg                          ? cfgReg :
        selFsIn0                        ? fsInWord0 :
        selFsIn1                        ? fsInWord1 :
        selFsOut                        ? fsOutImg :
        selStat                         ? {27'h000_0000, irqStatus} :
        selMask                         ? {27'h000_0000, irqMask} :
        selRes                          ? {8'h00, reserveReg} :
                                          32'h0000_0000;

    // Bus answer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= busRd ? rdData : 32'h0000_0000;
        end
    end

    // Writable image and control registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ledImgLo   <= `PPIM_IMG_RST;
            ledImgHi   <= `PPIM_IMG_RST;
            outImg     <= 16'h0000;
            cfgReg     <= `PPIM_CFG_RST;
            fsOutImg   <= `PPIM_IMG_RST;
            reserveReg <= `PPIM_RESERVE_RST;
            irqMask    <= `PPIM_MASK_RST;
        end else begin
            if (wrLedLo) ledImgLo <= mergeWr(ledImgLo, wb_dat_i, byteMask);
            if (wrLedHi) ledImgHi <= mergeWr(ledImgHi, wb_dat_i, byteMask);
            if (wrStdOut) outImg <= 16'(mergeWr({16'h0000, outImg}, wb_dat_i, byteMask));
            if (wrCfg) cfgReg <= mergeWr(cfgReg, wb_dat_i, byteMask) & 32'h0000_ff03;
            if (wrFsOut) fsOutImg <= mergeWr(fsOutImg, wb_dat_i, byteMask);
            if (wrRes) reserveReg <= 24'(mergeWr({8'h00, reserveReg}, wb_dat_i, byteMask));
            if (wrMask) irqMask <= `PPIM_IRQ_BITS'(mergeWr({27'h000_0000, irqMask}, wb_dat_i, byteMask));
        end
    end

    // Sticky status, read clears, a same-cycle event survives
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStatus <= `PPIM_MASK_RST;
            keyPrev   <= 32'h0000_0000;
            stdInPrev <= 32'h0000_0000;
            estopPrev <= 2'b00;
            irq       <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus;
            keyPrev   <= keyWord;
            stdInPrev <= stdInWord;
            estopPrev <= estopFlag;
            irq       <= irqPending;
        end
    end

    // Pin outputs follow the image within one cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ledRed     <= 32'h0000_0000;
            ledGreen   <= 32'h0000_0000;
            stdOutPins <= 8'h00;
        end else begin
            ledRed     <= next_ledRed;
            ledGreen   <= next_ledGreen;
            stdOutPins <= next_stdOut;
        end
    end

endmodule
`default_nettype wire

// [rtl/ppim_dummy_end.sv]
`timescale 1ns/1ps

// [verif/ppim_top_asserts.sv]
// Port checker for the panel image mapper, bound into ppim_top.
// Assumes word-aligned full-word writes from a classic Wishbone master.
`timescale 1ns/1ps
`default_nettype none
`include "ppim_map.svh"
module ppim_checker (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq,
    input wire logic [31:0] keyPins,
    input wire logic [31:0] stdInPins,
    input wire logic [1:0]  safeChanInput1,
    input wire logic [1:0]  safeChanInput2,
    input wire logic [31:0] ledRed,
    input wire logic [31:0] ledGreen,
    input wire logic [7:0]  stdOutPins
);
    // Shadow: {mode, mask, reserved outs, outs, leds}; p lags one cycle like the pins
    logic [62:0]      sh;
    logic [62:0]      p;
    wire logic        wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    wire logic [31:0] d  = wb_dat_i;
    wire logic [62:0] next_sh = !wr ? sh
        : wb_adr_i == `PPIM_ADDR_LED_LO ? {sh[62:32], d}
        : wb_adr_i == `PPIM_ADDR_STDOUT ? {sh[62:48], d[15:0], sh[31:0]}
        : wb_adr_i == `PPIM_ADDR_RESERVE ? {sh[62:56], d[23:16], sh[47:0]}
        : wb_adr_i == `PPIM_ADDR_IRQMASK ? {sh[62:61], d[4:0], sh[55:0]}
        : wb_adr_i == `PPIM_ADDR_CFG ? {d[1:0], sh[60:0]} : sh;
    wire logic [15:0] r  = p[15:0];
    wire logic [15:0] gr = p[31:16];
    wire logic [7:0]  fo = p[39:32];
    wire logic [7:0]  so = p[47:40];
    wire logic [7:0]  rs = p[55:48];
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh <= '0;
            p  <= '0;
        end else begin
            sh <= next_sh;
            p  <= sh;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    red_only_a: assert property ((r & ~gr & (~ledRed[15:0] | ledGreen[15:0])) == '0)
        else $error("red-only led wrong");
    green_only_a: assert property ((gr & ~r & (ledRed[15:0] | ~ledGreen[15:0])) == '0)
        else $error("green-only led wrong");
    led_off_a: assert property ((~r & ~gr & (ledRed[15:0] | ledGreen[15:0])) == '0)
        else $error("dark led lit");
    combo_yellow_a: assert property (p[62:61] == ppim_pkg::PPIM_COMBO_YELLOW
        |-> (r & gr & ~(ledRed[15:0] & ledGreen[15:0])) == '0) else $error("yellow not steady");
    combo_green_a: assert property (p[62:61] == ppim_pkg::PPIM_COMBO_FLASH_GREEN
        |-> (r & gr & ledRed[15:0]) == '0) else $error("red in flashing green");
    out_steady_a: assert property ((fo & ~so & ~rs & ~stdOutPins) == '0)
        else $error("steady output not on");
    out_off_a: assert property ((((~fo & ~so) | rs) & stdOutPins) == '0)
        else $error("off or reserved output driven");
    irq_masked_a: assert property (p[60:56] == '0 |-> !irq)
        else $error("irq with all masked");
    cover property (wb_ack_o && !wb_we_i);
    cover property (irq);
    cover property (p[62:61] == 2'h1 && (r & gr) != '0);
endmodule
bind ppim_top ppim_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .keyPins(keyPins),
    .stdInPins(stdInPins), .safeChanInput1(safeChanInput1), .safeChanInput2(safeChanInput2),
    .ledRed(ledRed), .ledGreen(ledGreen), .stdOutPins(stdOutPins));
`default_nettype wire

// [verif/ppim_ctrl_model.sv]
// Remote IO controller model: classic Wishbone master writing the output image.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
`default_nettype none
`include "ppim_map.svh"
module ppim_ctrl_model (
    input  wire logic        core_clk,
    input  wire logic        wb_ack_o,
    output var  logic        cyc,
    output var  logic        stb,
    output var  logic        we,
    output var  logic [7:0]  adr,
    output var  logic [3:0]  sel,
    output var  logic [31:0] dat,
    output var  logic        hung
);
    initial {cyc, stb, we, adr, sel, dat, hung} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
        int i;
        repeat ($urandom % 2) @(posedge core_clk);
        @(posedge core_clk);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hf, v};
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 64);
        hung <= wb_ack_o !== 1'b1;
        {cyc, stb} <= 2'b00;
        // Released we, adr and dat lines must not keep their last value
        {we, adr, dat} <= ~{we, adr, dat};
    endtask
    task automatic led_img(input logic hi, input logic [15:0] red, input logic [15:0] green);
        xfer(1'b1, hi ? `PPIM_ADDR_LED_HI : `PPIM_ADDR_LED_LO, {green, red});
    endtask
    task automatic out_img(input logic [7:0] first, input logic [7:0] second);
        xfer(1'b1, `PPIM_ADDR_STDOUT, {16'h0000, second, first});
    endtask
endmodule
`default_nettype wire

// [verif/tb_panel_process_image_mapper.sv]
// Self-checking bench for the panel image mapper with shortened flash and discrepancy counts.
// Assumes the controller model drives the bus and a read monitor consumes expected values.
`timescale 1ns/1ps
`default_nettype none
`include "ppim_map.svh"
module tb_panel_process_image_mapper;
    localparam int FH = 4;
    localparam int SH = 16;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [31:0] keyPins = '0;
    logic [31:0] stdInPins = '0;
    logic [1:0]  safeChanInput1 = '0;
    logic [1:0]  safeChanInput2 = '0;
    wire         cyc, stb, we, ack, irq, hung;
    wire [7:0]   adr, stdOutPins;
    wire [3:0]   sel;
    wire [31:0]  dat, rdat, ledRed, ledGreen;
    int          n_errors = 0;
    int          checked = 0;
    logic [31:0] expQ[$];
    logic [31:0] k, d;
    logic [3:0]  acc;
    logic [7:0]  po;
    int          hc[5], tg[5];
    logic [3:0]  combo[4] = '{4'b0010, 4'b1111, 4'b1010, 4'b1000};
    int          hx[5] = '{0, 64, 32, 32, 0};
    int          tx[5] = '{0, 0, 16, 4, 0};
    always #2 core_clk = ~core_clk;
    ppim_top #(.FAST_HALF(FH), .SLOW_HALF(SH), .DISC_CYC(10)) u_dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
        .keyPins(keyPins), .stdInPins(stdInPins), .safeChanInput1(safeChanInput1),
        .safeChanInput2(safeChanInput2), .ledRed(ledRed), .ledGreen(ledGreen), .stdOutPins(stdOutPins));
    ppim_ctrl_model u_ctrl (.core_clk(core_clk), .wb_ack_o(ack), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .dat(dat), .hung(hung));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        u_ctrl.xfer(1'b0, a, '0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        u_ctrl.xfer(1'b1, a, v);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic close_out;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Read monitor: oldest expectation against data in the ack cycle
    always @(posedge core_clk) begin
        if (ack === 1'b1 && we === 1'b0) check(rdat, expQ.size() > 0 ? expQ.pop_front() : 'x);
    end
    always @(posedge hung) begin
        n_errors++;
        close_out();
    end
    initial begin
        void'($urandom(32'hab1c));
        tick(3);
        sys_rst <= 1'b0;
        rd(`PPIM_ADDR_CFG, '0);
        rd(`PPIM_ADDR_IRQMASK, '0);
        wr(`PPIM_ADDR_RESERVE, 32'h0001_000f);
        wr(8'h30, '1);
        rd(8'h30, '0);
        rd(`PPIM_ADDR_FSIN1, '0);
        k = $urandom | 32'h1;
        d = $urandom | 32'h10;
        keyPins <= k;
        stdInPins <= d;
        tick(4);
        rd(`PPIM_ADDR_KEYS, k);
        rd(`PPIM_ADDR_STDIN, d & ~32'h0000_000f);
        rd(`PPIM_ADDR_IRQSTAT, 32'h3);
        rd(`PPIM_ADDR_IRQSTAT, '0);
        u_ctrl.led_img(1'b0, 16'h0005, 16'h0006);
        u_ctrl.led_img(1'b1, 16'h8000, 16'h0000);
        rd(`PPIM_ADDR_LED_LO, 32'h0006_0005);
        for (int m = 0; m < 4; m++) begin
            wr(`PPIM_ADDR_CFG, m);
            tick(2);
            acc = 4'b0101;
            repeat (2 * FH) begin
                acc = (acc | {ledRed[2], 1'b0, ledGreen[2], 1'b0}) & {1'b1, ledRed[2], 1'b1, ledGreen[2]};
                @(posedge core_clk);
            end
            check({28'h0, acc}, {28'h0, combo[m]});
            check({ledRed[31], ledRed[3], ledRed[1:0], ledGreen[31], ledGreen[3], ledGreen[1:0]}, 8'h92);
        end
        u_ctrl.out_img(8'h0b, 8'h0c);
        rd(`PPIM_ADDR_STDOUT, 32'h0000_0c0b);
        tick(2);
        hc = '{default: 0};
        tg = '{default: 0};
        po = stdOutPins;
        repeat (64) begin
            @(posedge core_clk);
            for (int i = 0; i < 5; i++) begin
                hc[i] += stdOutPins[i];
                tg[i] += stdOutPins[i] ^ po[i];
            end
            po = stdOutPins;
        end
        for (int i = 0; i < 5; i++) begin
            check(32'(hc[i]), 32'(hx[i]));
            check(32'(tg[i]), 32'(tx[i]));
        end
        wr(`PPIM_ADDR_CFG, 32'h0000_2a00);
        rd(`PPIM_ADDR_CFG, 32'h0000_2a00);
        wr(`PPIM_ADDR_FSOUT, k);
        rd(`PPIM_ADDR_FSOUT, k);
        safeChanInput1 <= 2'b11;
        safeChanInput2 <= 2'b11;
        tick(5);
        rd(`PPIM_ADDR_FSIN0, 32'h0000_0f03);
        safeChanInput2 <= 2'b01;
        tick(20);
        rd(`PPIM_ADDR_FSIN0, 32'h0000_0701);
        rd(`PPIM_ADDR_IRQSTAT, 32'h0000_001c);
        wr(`PPIM_ADDR_IRQMASK, 32'h1);
        keyPins <= ~k;
        tick(6);
        check({31'h0, irq}, 32'h1);
        rd(`PPIM_ADDR_IRQSTAT, 32'h1);
        tick(2);
        check({31'h0, irq}, '0);
        wr(`PPIM_ADDR_IRQMASK, '0);
        keyPins <= k;
        tick(6);
        check({31'h0, irq}, '0);
        rd(`PPIM_ADDR_IRQSTAT, 32'h1);
        tick(2);
        check(32'(expQ.size()), '0);
        close_out();
    end
endmodule
`default_nettype wire
